// File: rtl/dual_timer_counter.sv
// Functional notes
// - mode 0 counts thirteen bits: high byte plus low byte bits 4..0.
// - timer counts only when run is set and gate is off or qualify pin high.
// - rollover to zero sets overflow flag and raises interrupt if unmasked.
// - count tick is half clock rate in twelve-clock mode, full in six-clock.
// - timer 1 in mode 3 holds its count frozen.
// - timer 0 mode 3 splits into two 8-bit counters; low uses timer 0 controls.
// - split low byte in external mode counts falling edges of count pin.
// - split high byte counts ticks, runs on timer 1 run, sets timer 1 flag.
// - with timer 0 split, timer 1 starts or stops by leaving or entering mode 3.
// - with timer 0 split, timer 1 runs modes 0-2 gated, without flag or run.
// - high and low count registers hold bits 15..8 and 7..0, read and write.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter
  import timer_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // axi4-lite write
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  output var  logic [1:0]            s_axi_bresp,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  output var  logic [31:0]           s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // pins
  input  wire logic                  timer0_count_pin,
  input  wire logic                  timer1_count_pin,
  input  wire logic                  qualify_pin_zero,
  input  wire logic                  qualify_pin_one,
  // interrupt
  output var  logic                  irq
);

  logic [7:0]       run_flag_reg, cfg_reg;
  logic [7:0]       cnt0_low_reg, cnt0_high_reg, cnt1_low_reg, cnt1_high_reg;
  timer_cfg_t       cfg0, cfg1;
  logic [1:0]       stat_reg, mask_reg;
  logic             six_clock_reg, tick_reg;
  logic [2:0]       pin0_sync, pin1_sync;
  logic             fall0, fall1;
  logic             inc0, inc_h0, inc1, split0;
  logic             ovf0, ovf1;
  logic [16:0]      r0, r1;
  logic [8:0]       c8l, c8h;
  logic [7:0]       cnt0_low_next, cnt0_high_next, cnt1_low_next, cnt1_high_next;
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic [7:0]       wdata_reg;
  logic             wstrb_reg, wr_en;
  logic [7:0]       widx, ridx, rd_byte;
  logic             rd_hit, wr_hit;

  // ---------------------------------------------------------------
  // tick and pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= six_clock_reg | ~tick_reg;
    end
  end

  // third stage only feeds the edge detector, never the first stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin0_sync <= 3'b000;
      pin1_sync <= 3'b000;
    end else begin
      pin0_sync <= {pin0_sync[1:0], timer0_count_pin};
      pin1_sync <= {pin1_sync[1:0], timer1_count_pin};
    end
  end

  assign fall0 = pin0_sync[2] & ~pin0_sync[1];
  assign fall1 = pin1_sync[2] & ~pin1_sync[1];

  // ---------------------------------------------------------------
  // count logic
  // ---------------------------------------------------------------
  function automatic logic [16:0] bump(input mode_t m, input logic [7:0] lo,
                                       input logic [7:0] hi, input logic inc);
    logic [13:0] c13;
    logic [16:0] c16;
    logic [8:0]  c8;
    c13  = {1'b0, hi, lo[4:0]} + 14'd1;
    c16  = {1'b0, hi, lo} + 17'd1;
    c8   = {1'b0, lo} + 9'd1;
    bump = {1'b0, hi, lo};
    if (inc) begin
      case (m)
        mode_13bit:       bump = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
        mode_16bit:       bump = c16;
        mode_auto_reload: bump = {c8[8], hi, c8[8] ? hi : c8[7:0]};
        default:          bump = {1'b0, hi, lo};
      endcase
    end
  endfunction

  assign cfg0   = timer_cfg_t'(cfg_reg[3:0]);
  assign cfg1   = timer_cfg_t'(cfg_reg[7:4]);
  assign split0 = (cfg0.mode == mode_split);

  assign inc0 = run_flag_reg[FLD_TIMER0_RUN] & (~cfg0.gate | qualify_pin_zero)
              & (cfg0.count_src ? fall0 : tick_reg);
  assign inc_h0 = split0 & run_flag_reg[FLD_TIMER1_RUN] & tick_reg;
  // timer 1 loses its run bit to the split high byte; mode 3 then stops it
  assign inc1 = (split0 | run_flag_reg[FLD_TIMER1_RUN]) & (cfg1.mode != mode_split)
              & (~cfg1.gate | qualify_pin_one)
              & (cfg1.count_src ? fall1 : tick_reg);

  assign c8l = {1'b0, cnt0_low_reg} + {8'h00, inc0};
  assign c8h = {1'b0, cnt0_high_reg} + {8'h00, inc_h0};
  assign r0  = bump(cfg0.mode, cnt0_low_reg, cnt0_high_reg, inc0);
  assign r1  = bump(cfg1.mode, cnt1_low_reg, cnt1_high_reg, inc1);

  always_comb begin
    if (split0) begin
      cnt0_low_next  = c8l[7:0];
      cnt0_high_next = c8h[7:0];
      ovf0           = c8l[8];
      ovf1           = c8h[8];
    end else begin
      cnt0_low_next  = r0[7:0];
      cnt0_high_next = r0[15:8];
      ovf0           = r0[16];
      ovf1           = r1[16];
    end
    cnt1_low_next  = r1[7:0];
    cnt1_high_next = r1[15:8];
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign wr_en = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign widx  = awaddr_reg[9:2];
  assign ridx  = s_axi_araddr[9:2];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddr_reg    <= '0;
      wdata_reg     <= RESET_BYTE;
      wstrb_reg     <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awaddr_reg    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg    <= s_axi_wdata[7:0];
        wstrb_reg    <= s_axi_wstrb[0];
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_comb begin
    wr_hit = 1'b1;
    case (widx)
      IDX_RUN_FLAG_CTRL, IDX_MODE_SELECT, IDX_TIMER0_LOW, IDX_T1_COUNT_LOW,
      IDX_TIMER0_HIGH, IDX_T1_COUNT_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK,
      IDX_CLOCK_CONFIG: wr_hit = (awaddr_reg[ADDR_WIDTH-1:10] == '0);
      default:          wr_hit = 1'b0;
    endcase
  end

  function automatic logic wr_at(input logic [7:0] idx);
    wr_at = wr_en & wr_hit & wstrb_reg & (widx == idx);
  endfunction

  always_comb begin
    rd_hit  = (s_axi_araddr[ADDR_WIDTH-1:10] == '0);
    rd_byte = RESET_BYTE;
    case (ridx)
      IDX_RUN_FLAG_CTRL: rd_byte = run_flag_reg;
      IDX_MODE_SELECT:   rd_byte = cfg_reg;
      IDX_TIMER0_LOW:    rd_byte = cnt0_low_reg;
      IDX_T1_COUNT_LOW:  rd_byte = cnt1_low_reg;
      IDX_TIMER0_HIGH:   rd_byte = cnt0_high_reg;
      IDX_T1_COUNT_HIGH: rd_byte = cnt1_high_reg;
      IDX_IRQ_STATUS:    rd_byte = {6'b000000, stat_reg};
      IDX_IRQ_MASK:      rd_byte = {6'b000000, mask_reg};
      IDX_CLOCK_CONFIG:  rd_byte = {7'b0000000, six_clock_reg};
      default:           rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, rd_hit ? rd_byte : RESET_BYTE};
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers; a software write to a count byte wins over counting
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt0_low_reg  <= RESET_BYTE;
      cnt0_high_reg <= RESET_BYTE;
      cnt1_low_reg  <= RESET_BYTE;
      cnt1_high_reg <= RESET_BYTE;
    end else begin
      cnt0_low_reg  <= wr_at(IDX_TIMER0_LOW)    ? wdata_reg : cnt0_low_next;
      cnt0_high_reg <= wr_at(IDX_TIMER0_HIGH)   ? wdata_reg : cnt0_high_next;
      cnt1_low_reg  <= wr_at(IDX_T1_COUNT_LOW)  ? wdata_reg : cnt1_low_next;
      cnt1_high_reg <= wr_at(IDX_T1_COUNT_HIGH) ? wdata_reg : cnt1_high_next;
    end
  end

  // overflow set wins over a software write of zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_flag_reg <= RESET_BYTE;
    end else begin
      if (wr_at(IDX_RUN_FLAG_CTRL)) begin
        run_flag_reg <= wdata_reg;
      end
      if (ovf0) begin
        run_flag_reg[FLD_TIMER0_OVERFLOW] <= 1'b1;
      end
      if (ovf1) begin
        run_flag_reg[FLD_TIMER1_OVERFLOW] <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_reg       <= RESET_BYTE;
      mask_reg      <= RESET_IRQ;
      six_clock_reg <= 1'b0;
    end else begin
      if (wr_at(IDX_MODE_SELECT)) begin
        cfg_reg <= wdata_reg;
      end
      if (wr_at(IDX_IRQ_MASK)) begin
        mask_reg <= wdata_reg[1:0];
      end
      if (wr_at(IDX_CLOCK_CONFIG)) begin
        six_clock_reg <= wdata_reg[CFG_SIX_CLOCK];
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stat_reg <= RESET_IRQ;
      irq      <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~(wr_at(IDX_IRQ_STATUS) ? wdata_reg[1:0] : 2'b00))
                | {ovf1, ovf0};
      irq      <= |(stat_reg & mask_reg);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic quiet;
  assign quiet = ~wr_en;

  sequence pin0_fall_seen;
    (split0 && cfg0.count_src && run_flag_reg[FLD_TIMER0_RUN] && !cfg0.gate && quiet
     && timer0_count_pin)
    ##1 (split0 && cfg0.count_src && run_flag_reg[FLD_TIMER0_RUN] && !cfg0.gate && quiet
     && !timer0_count_pin)
    ##1 (split0 && cfg0.count_src && run_flag_reg[FLD_TIMER0_RUN] && !cfg0.gate && quiet)[*2];
  endsequence

  a_mode0_rollover: assert property (
    (cfg0.mode == mode_13bit && inc0 && quiet && cnt0_high_reg == 8'hff
     && cnt0_low_reg[4:0] == 5'h1f)
    |=> (run_flag_reg[FLD_TIMER0_OVERFLOW] && cnt0_high_reg == 8'h00
     && cnt0_low_reg[4:0] == 5'h00))
    else $error("mode 0 rollover did not clear count and set flag");

  a_gate_hold_count: assert property (
    (cfg0.mode == mode_16bit && cfg0.gate && !qualify_pin_zero && quiet)
    |=> ({cnt0_high_reg, cnt0_low_reg} == $past({cnt0_high_reg, cnt0_low_reg})))
    else $error("timer 0 counted while gated off");

  a_t1_freeze: assert property (
    (cfg1.mode == mode_split && quiet)
    |=> ({cnt1_high_reg, cnt1_low_reg} == $past({cnt1_high_reg, cnt1_low_reg})))
    else $error("timer 1 moved in mode 3");

  a_split_high_flag: assert property (
    (split0 && run_flag_reg[FLD_TIMER1_RUN] && tick_reg && cnt0_high_reg == 8'hff && quiet)
    |=> (run_flag_reg[FLD_TIMER1_OVERFLOW] && cnt0_high_reg == 8'h00))
    else $error("split high byte overflow did not set timer 1 flag");

  a_split_low_wrap: assert property (
    (split0 && inc0 && !inc_h0 && cnt0_low_reg == 8'hff && quiet)
    |=> (cnt0_low_reg == 8'h00 && run_flag_reg[FLD_TIMER0_OVERFLOW]
     && cnt0_high_reg == $past(cnt0_high_reg)))
    else $error("split low byte wrap wrong");

  a_ext_fall_count: assert property (
    pin0_fall_seen |=> (cnt0_low_reg == 8'($past(cnt0_low_reg) + 8'h01)))
    else $error("split low byte missed a pin falling edge");

  a_reload_high: assert property (
    (cfg0.mode == mode_auto_reload && inc0 && cnt0_low_reg == 8'hff && quiet)
    |=> (cnt0_low_reg == cnt0_high_reg && run_flag_reg[FLD_TIMER0_OVERFLOW]))
    else $error("auto reload did not load the high byte");

  a_t1_split_run: assert property (
    (split0 && cfg1.mode == mode_16bit && !cfg1.gate && !cfg1.count_src && tick_reg
     && {cnt1_high_reg, cnt1_low_reg} != 16'hffff && quiet)
    |=> ({cnt1_high_reg, cnt1_low_reg} == 16'($past({cnt1_high_reg, cnt1_low_reg}) + 16'h0001)))
    else $error("timer 1 stopped while timer 0 split");

  a_tick_half_rate: assert property (
    (!six_clock_reg && tick_reg && quiet) |=> !tick_reg ##1 tick_reg)
    else $error("twelve-clock tick not every second cycle");

  a_flag_set_wins: assert property (
    (ovf0 && wr_at(IDX_RUN_FLAG_CTRL)) |=> run_flag_reg[FLD_TIMER0_OVERFLOW])
    else $error("overflow lost against software clear");

  a_irq_follows: assert property (
    (stat_reg & mask_reg) != 2'b00 |=> irq)
    else $error("unmasked status did not raise interrupt");

endmodule
`default_nettype wire

// File: rtl/timer_pkg.sv
package timer_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_RUN_FLAG_CTRL = 8'h88;
  localparam logic [7:0] IDX_MODE_SELECT   = 8'h89;
  localparam logic [7:0] IDX_TIMER0_LOW    = 8'h8a;
  localparam logic [7:0] IDX_T1_COUNT_LOW  = 8'h8b;
  localparam logic [7:0] IDX_TIMER0_HIGH   = 8'h8c;
  localparam logic [7:0] IDX_T1_COUNT_HIGH = 8'h8d;
  localparam logic [7:0] IDX_IRQ_STATUS    = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK      = 8'h91;
  localparam logic [7:0] IDX_CLOCK_CONFIG  = 8'h92;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FLD_TIMER1_OVERFLOW  = 7;
  localparam int FLD_TIMER1_RUN       = 6;
  localparam int FLD_TIMER0_OVERFLOW  = 5;
  localparam int FLD_TIMER0_RUN       = 4;
  localparam int STAT_TIMER0_OVERFLOW = 0;
  localparam int STAT_TIMER1_OVERFLOW = 1;
  localparam int CFG_SIX_CLOCK        = 0;

  // ---------------------------------------------------------------
  // reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE  = 8'h00;
  localparam logic [1:0] RESET_IRQ   = 2'b00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    mode_13bit,
    mode_16bit,
    mode_auto_reload,
    mode_split
  } mode_t;

  typedef struct packed {
    logic  gate;
    logic  count_src;
    mode_t mode;
  } timer_cfg_t;

endpackage

// File: sim/pin_stimulus.sv
`timescale 1ns/1ps
`default_nettype none
module pin_stimulus (
  // clock
  input  wire logic       ref_clk,
  // requests from the bench
  input  wire logic       edge_go,
  input  wire logic [7:0] edge_num,
  input  wire logic       gate_zero,
  input  wire logic       gate_one,
  // pins towards the timer block
  output var  logic       timer0_count_pin,
  output var  logic       timer1_count_pin,
  output var  logic       qualify_pin_zero,
  output var  logic       qualify_pin_one
);
  logic [7:0] left_reg  = 8'h00;
  logic [2:0] phase_reg = 3'h0;

  // ------------------------------------------------------------
  // burst of falling edges
  // ------------------------------------------------------------
  // four cycles high, four low: slow enough for the three-flop sync
  always @(posedge ref_clk) begin
    if (edge_go) begin
      left_reg  <= edge_num;
      phase_reg <= 3'h0;
    end else if (left_reg != 8'h00) begin
      phase_reg <= phase_reg + 3'h1;
      if (phase_reg == 3'h7) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end

  // idle high, so no stray falling edge between bursts
  assign timer0_count_pin = (left_reg == 8'h00) || !phase_reg[2];
  assign timer1_count_pin = timer0_count_pin;
  assign qualify_pin_zero = gate_zero;
  assign qualify_pin_one  = gate_one;
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import timer_pkg::*;
;
  logic        ref_clk;
  logic        reset;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        timer0_count_pin;
  logic        timer1_count_pin;
  logic        qualify_pin_zero;
  logic        qualify_pin_one;
  logic        irq;
  logic        edge_go;
  logic [7:0]  edge_num;
  logic        gate_zero;
  logic        gate_one;
  int          err_count;
  int          n_tests;

  dual_timer_counter #(.ADDR_WIDTH(12)) i_dual_timer_counter (
    .ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer0_count_pin(timer0_count_pin), .timer1_count_pin(timer1_count_pin),
    .qualify_pin_zero(qualify_pin_zero), .qualify_pin_one(qualify_pin_one), .irq(irq));

  pin_stimulus i_pin_stimulus (
    .ref_clk(ref_clk), .edge_go(edge_go), .edge_num(edge_num), .gate_zero(gate_zero),
    .gate_one(gate_one), .timer0_count_pin(timer0_count_pin),
    .timer1_count_pin(timer1_count_pin), .qualify_pin_zero(qualify_pin_zero),
    .qualify_pin_one(qualify_pin_one));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ------------------------------------------------------------
  // bus and checking tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st,
                    output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr  <= {2'b00, idx, 2'b00};
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge ref_clk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_araddr  <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    d    = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    check(d, {24'h00_0000, exp});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_map;
    logic [7:0]  ids [9] = '{IDX_RUN_FLAG_CTRL, IDX_MODE_SELECT, IDX_TIMER0_LOW,
      IDX_T1_COUNT_LOW, IDX_TIMER0_HIGH, IDX_T1_COUNT_HIGH, IDX_IRQ_STATUS, IDX_IRQ_MASK,
      IDX_CLOCK_CONFIG};
    logic [31:0] d;
    logic [1:0]  r;
    foreach (ids[i]) rc(ids[i], RESET_BYTE);
    rd(8'h80, d, r);
    check(d, 32'h0000_0000);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h80, 8'h55, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_SLVERR});
    check({31'h0, irq}, 32'h0000_0000);
    $display("test reset_map done");
  endtask

  task automatic t_count_regs;
    logic [7:0] ids [4] = '{IDX_TIMER0_LOW, IDX_T1_COUNT_LOW, IDX_TIMER0_HIGH,
      IDX_T1_COUNT_HIGH};
    logic [1:0] r;
    foreach (ids[i]) w(ids[i], 8'h5a + 8'(i));
    foreach (ids[i]) rc(ids[i], 8'h5a + 8'(i));
    wr(IDX_TIMER0_LOW, 8'h11, 4'h0, r);
    rc(IDX_TIMER0_LOW, 8'h5a);
    $display("test count_regs done");
  endtask

  task automatic t_mode0_irq;
    w(IDX_MODE_SELECT, 8'h00);
    w(IDX_TIMER0_HIGH, 8'hff);
    // low five bits at maximum, upper bits must not matter
    w(IDX_TIMER0_LOW, 8'h3f);
    w(IDX_RUN_FLAG_CTRL, 8'h10); // reserved bits kept zero
    repeat (20) @(posedge ref_clk);
    rc(IDX_RUN_FLAG_CTRL, 8'h30);
    rc(IDX_TIMER0_HIGH, 8'h00);
    rc(IDX_IRQ_STATUS, 8'h01);
    check({31'h0, irq}, 32'h0000_0000);
    w(IDX_IRQ_MASK, 8'h01);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0000_0001);
    w(IDX_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0000_0000);
    w(IDX_RUN_FLAG_CTRL, 8'h00);
    $display("test mode0_irq done");
  endtask

  task automatic t_gate;
    logic [31:0] d;
    logic [1:0]  r;
    w(IDX_MODE_SELECT, 8'h08);
    w(IDX_TIMER0_LOW, 8'h00);
    w(IDX_RUN_FLAG_CTRL, 8'h10);
    repeat (40) @(posedge ref_clk);
    rc(IDX_TIMER0_LOW, 8'h00);
    gate_zero <= 1'b1;
    repeat (40) @(posedge ref_clk);
    rd(IDX_TIMER0_LOW, d, r);
    check({31'h0, d[7:0] > 8'h10}, 32'h0000_0001);
    gate_zero <= 1'b0;
    w(IDX_RUN_FLAG_CTRL, 8'h00);
    $display("test gate done");
  endtask

  task automatic measure(input logic [7:0] cfg, output logic [31:0] d);
    logic [1:0] r;
    w(IDX_CLOCK_CONFIG, cfg);
    w(IDX_TIMER0_LOW, 8'h00);
    w(IDX_RUN_FLAG_CTRL, 8'h10);
    repeat (64) @(posedge ref_clk);
    w(IDX_RUN_FLAG_CTRL, 8'h00);
    rd(IDX_TIMER0_LOW, d, r);
  endtask

  task automatic t_rate;
    logic [31:0] slow;
    logic [31:0] fast;
    w(IDX_MODE_SELECT, 8'h01);
    measure(8'h00, slow);
    measure(8'h01, fast);
    // same bus overhead in both runs, so only a one-count skew
    check({31'h0, fast + 1 >= 2 * slow && fast <= 2 * slow + 1}, 32'h0000_0001);
    w(IDX_CLOCK_CONFIG, 8'h00);
    $display("test rate done");
  endtask

  task automatic t_split;
    logic [31:0] a;
    logic [31:0] b;
    logic [1:0]  r;
    w(IDX_MODE_SELECT, 8'h17);
    w(IDX_TIMER0_LOW, 8'h00);
    w(IDX_TIMER0_HIGH, 8'hf0);
    w(IDX_T1_COUNT_LOW, 8'h00);
    w(IDX_RUN_FLAG_CTRL, 8'h50);
    @(posedge ref_clk);
    edge_num <= 8'h05;
    edge_go  <= 1'b1;
    @(posedge ref_clk);
    edge_go <= 1'b0;
    repeat (60) @(posedge ref_clk);
    rc(IDX_TIMER0_LOW, 8'h05);
    rc(IDX_RUN_FLAG_CTRL, 8'hd0);
    rc(IDX_IRQ_STATUS, 8'h02);
    w(IDX_MODE_SELECT, 8'h37);
    rd(IDX_T1_COUNT_LOW, a, r);
    repeat (20) @(posedge ref_clk);
    rd(IDX_T1_COUNT_LOW, b, r);
    check(b, a);
    w(IDX_MODE_SELECT, 8'h17);
    repeat (20) @(posedge ref_clk);
    rd(IDX_T1_COUNT_LOW, a, r);
    check({31'h0, a > b}, 32'h0000_0001);
    w(IDX_RUN_FLAG_CTRL, 8'h00);
    w(IDX_IRQ_STATUS, 8'h03);
    $display("test split done");
  endtask

  task automatic t_reload;
    logic [31:0] d;
    logic [1:0]  r;
    w(IDX_MODE_SELECT, 8'h02);
    w(IDX_TIMER0_HIGH, 8'ha0);
    w(IDX_TIMER0_LOW, 8'hfe);
    w(IDX_RUN_FLAG_CTRL, 8'h10);
    repeat (20) @(posedge ref_clk);
    rc(IDX_RUN_FLAG_CTRL, 8'h30);
    w(IDX_RUN_FLAG_CTRL, 8'h00);
    rd(IDX_TIMER0_LOW, d, r);
    check({31'h0, d >= 32'h0000_00a0 && d < 32'h0000_00c0}, 32'h0000_0001);
    rc(IDX_TIMER0_HIGH, 8'ha0);
    $display("test reload done");
  endtask

  // ------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // tests need some 650 cycles; allow far more
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0;
    n_tests = 0;
    {reset, edge_go, gate_zero, gate_one, edge_num} = {1'b1, 11'h000};
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset_map();
    t_count_regs();
    t_mode0_irq();
    t_gate();
    t_rate();
    t_split();
    t_reload();
    give_verdict();
  end
endmodule
`default_nettype wire
